/* design/bms_sequencer.sv */
// Bridge measurement sequencer with converter setup and APB registers.
//
// Contract
// RL1: Two offset paths: digital plus analog pre-compensation.
// RL2: Six-bit stored field sets analog pre-compensation.
// RL3: Step code accepted from minus to plus 31.
// RL4: Compensation voltage scales with code, k, gain.
// RL5: Repeat count from cycle word bits 9:7.
// RL6: One bit includes second temperature slots.
// RL7: Start routine measures bridge, optional main temperature.
// RL8: Fixed repeating order of bridge and special slots.
// RL9: Auto-zero slots short input, measure offset.
// RL10: First order: 9 to 14 bits, 2^r us.
// RL11: Second order: 11 to 15 bits, shorter time.
// RL12: Count uses resolution, reference and range shift.
// RL13: Range shift chosen from four stored fractions.
// RL14: Reference is bridge top or analog supply.
// RL15: Analog supply reference needs zero enabled code; ref_sel follows its stored bit whatever XZC_CODE holds.
// RL16: Output resolution follows converter resolution, capped.
// RL17: Pick resolution one to two bits above output.
// RL18: Sequencer drives multiplexer and conversion starts.
// RL19: Each result carries a channel tag.
`timescale 1ns/1ps
module bms_sequencer #(
   parameter int US_CYCLES = bms_pkg::US_CYC  // Clock cycles per microsecond.
) (
   input wire logic SYS_CLK,                  // System clock, 25 MHz.
   input wire logic RST,                      // Synchronous reset, high.
   input wire logic PSEL,                     // APB select.
   input wire logic PENABLE,                  // APB access phase.
   input wire logic PWRITE,                   // APB write.
   input wire logic [7:0] PADDR,              // APB byte address.
   input wire logic [31:0] PWDATA,            // APB write data.
   output logic [31:0] PRDATA,                // APB read data.
   output logic PREADY,                       // APB ready.
   output logic PSLVERR,                      // APB error, unmapped address.
   input wire logic [15:0] CONV_DATA,         // Count from the converter.
   output logic [2:0] MUX_SEL,                // Multiplexer channel.
   output logic AUTO_ZERO,                    // Short the selected input.
   output logic CONV_START,                   // Conversion start pulse.
   output bms_pkg::bms_conv_t CONV_CFG,       // Converter setup.
   output logic [4:0] OUT_RES,                // Analog output resolution.
   output logic [4:0] PWM_RES,                // Pulse-width output resolution.
   output logic [5:0] XZC_CODE,               // Signed pre-compensation step.
   output logic XZC_ENABLE,                   // Pre-compensation on.
   output bms_pkg::bms_sample_t SAMPLE,       // Tagged conversion result.
   output logic SAMPLE_VALID                  // Pulse with each result.
);
   import bms_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum {ST_IDLE, ST_START, ST_CONV, ST_NEXT} bms_state_t;

   logic [15:0] cycle_config_word;  // Stored cycle configuration.
   logic [15:0] conv_word;          // Stored converter setup.
   logic [8:0] xzc_word;            // Stored pre-compensation field.
   bms_state_t state;               // Sequencer state.
   logic in_start;                  // Start routine still running.
   logic [1:0] start_step;          // Slot within the start routine.
   logic [3:0] phase;               // Slot within the main cycle.
   logic [7:0] rep;                 // Bridge repeats done in this run.
   bms_tag_t cur_tag;               // Channel of the running slot.
   logic tick;                      // Microsecond enable.
   logic conv_done;                 // Conversion time elapsed.
   logic [3:0] conv_exp;            // Time exponent of a conversion.
   logic [3:0] res_eff;             // Resolution after limiting.
   logic [7:0] n_count;             // Bridge repeat count.
   logic second_temp_enable;        // Second temperature slots on.
   logic main_temp_enable;          // Main temperature in start routine.
   logic setup;                     // APB setup cycle seen.
   logic [31:0] rd_mux;             // Read data for the address.
   logic hit;                       // Address is mapped.

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Limit a resolution to the range of the chosen order.
   function automatic logic [3:0] clamp_res(input logic ord, input logic [3:0] r);
      logic [3:0] lo;
      logic [3:0] hi;
      lo = ord ? RES2_MIN : RES1_MIN;
      hi = ord ? RES2_MAX : RES1_MAX;
      if (r < lo) begin
         clamp_res = lo;
      end else if (r > hi) begin
         clamp_res = hi;
      end else begin
         clamp_res = r;
      end
   endfunction

   // Cap a resolution at a given output width.
   function automatic logic [4:0] cap_res(input logic [3:0] r, input logic [4:0] cap);
      cap_res = ({1'b0, r} > cap) ? cap : {1'b0, r};
   endfunction

   // Map a main-cycle phase to its channel; even phases are bridge runs.
   function automatic bms_tag_t phase_tag(input logic [3:0] p);
      case (p)
         4'h1: phase_tag = TAG_T1_AZ;
         4'h3: phase_tag = TAG_T1;
         4'h5: phase_tag = TAG_BRIDGE_AZ;
         4'h7: phase_tag = TAG_T2_AZ;
         4'h9: phase_tag = TAG_T2;
         4'hb: phase_tag = TAG_CM;
         default: phase_tag = TAG_BRIDGE;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Decoded configuration
   // ----------------------------------------------------------------
   // RL5: repeat count from cycle bits.
   assign n_count = 8'h01 << cycle_config_word[CYC_N_LO +: 3];
   // RL6: second temperature enable bit.
   assign second_temp_enable = cycle_config_word[CYC_T2E];
   assign main_temp_enable = cycle_config_word[CYC_T1E];
   assign res_eff = clamp_res(conv_word[CONV_ORDER], conv_word[CONV_RES_LO +: 4]);
   // RL10: first order waits 2^r us.
   // RL11: second order waits 2^((r+3)/2) us.
   assign conv_exp = conv_word[CONV_ORDER] ? 4'((5'(res_eff) + 5'd3) >> 1) : res_eff;

   // ----------------------------------------------------------------
   // Timing helpers
   // ----------------------------------------------------------------
   bms_tick #(
      .DIV(US_CYCLES)
   ) u_tick (
      .clk(SYS_CLK),
      .rst(RST),
      .tick(tick)
   );

   bms_conv_timer u_timer (
      .clk(SYS_CLK),
      .rst(RST),
      .tick(tick),
      .start(CONV_START),
      .expo(conv_exp),
      .done(conv_done)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   assign setup = PSEL && !PENABLE && !PREADY;
   assign hit = (PADDR == OFS_CYCLE) || (PADDR == OFS_CONV) || (PADDR == OFS_XZC) ||
                (PADDR == OFS_STATUS) || (PADDR == OFS_RESULT);

   // Select the read word for the current address.
   always_comb begin
      case (PADDR)
         OFS_CYCLE: rd_mux = {16'h0000, cycle_config_word};
         OFS_CONV: rd_mux = {16'h0000, conv_word};
         OFS_XZC: rd_mux = {23'h000000, xzc_word};
         OFS_STATUS: rd_mux = {rep, 4'h0, phase, 5'h00, cur_tag, 4'h0,
                               start_step, in_start, state != ST_IDLE};
         OFS_RESULT: rd_mux = {13'h0000, SAMPLE};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Answer every transfer after one access cycle.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup && !hit;
         if (setup && !PWRITE) begin
            PRDATA <= rd_mux;
         end
      end
   end

   // Store configuration words on a completed write.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cycle_config_word <= CYCLE_RST;
         conv_word <= CONV_RST;
         xzc_word <= XZC_RST;
      end else if (PSEL && PENABLE && PREADY && PWRITE) begin
         case (PADDR)
            OFS_CYCLE: cycle_config_word <= PWDATA[15:0];
            OFS_CONV: conv_word <= PWDATA[15:0];
            // RL3: minus 32 is not a legal step, take minus 31.
            OFS_XZC: xzc_word <= {PWDATA[8], 2'h0, (PWDATA[5:0] == XZC_NEG_OVR) ?
                                  XZC_NEG_MAX : PWDATA[5:0]};
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Analog and converter setup outputs
   // ----------------------------------------------------------------
   // Drive the setup pins from the stored words.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         CONV_CFG <= '0;
         OUT_RES <= 5'h00;
         PWM_RES <= 5'h00;
         XZC_CODE <= 6'h00;
         XZC_ENABLE <= 1'b0;
      end else begin
         // RL12: resolution, range shift and reference feed the count.
         // RL13: range shift from stored field.
         // RL14: reference source from stored bit.
         CONV_CFG <= '{order: conv_word[CONV_ORDER], res: res_eff,
                       rshift: conv_word[CONV_RS_LO +: 2], ref_sel: conv_word[CONV_REF]};
         // RL16: analog capped at 11, pulse-width at 12 bits.
         OUT_RES <= cap_res(res_eff, 5'h0b);
         PWM_RES <= cap_res(res_eff, 5'h0c);
         // RL1: analog path beside the digital correction downstream.
         // RL2: six-bit pre-compensation field.
         // RL4: code scales the added voltage with k and gain.
         XZC_CODE <= xzc_word[5:0];
         XZC_ENABLE <= xzc_word[XZC_EN];
      end
   end

   // ----------------------------------------------------------------
   // Measurement sequencer
   // ----------------------------------------------------------------
   // Walk the start routine, then the repeating cycle, one slot at a time.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state <= ST_IDLE;
         in_start <= 1'b1;
         start_step <= 2'h0;
         phase <= 4'h0;
         rep <= 8'h00;
         cur_tag <= TAG_BRIDGE_AZ;
         CONV_START <= 1'b0;
      end else begin
         CONV_START <= 1'b0;
         case (state)
            // RL7: after reset the start routine runs first.
            ST_IDLE: begin
               state <= ST_START;
               cur_tag <= TAG_BRIDGE_AZ;
            end
            // RL18: select channel and start the conversion.
            ST_START: begin
               CONV_START <= 1'b1;
               state <= ST_CONV;
            end
            ST_CONV: begin
               if (conv_done) begin
                  state <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               state <= ST_START;
               if (in_start) begin
                  // RL7: bridge auto-zero, bridge, then main temperature.
                  if (start_step == 2'h1 && !main_temp_enable) begin
                     in_start <= 1'b0;
                     phase <= 4'h0;
                     cur_tag <= TAG_BRIDGE;
                  end else if (start_step == 2'h3) begin
                     in_start <= 1'b0;
                     phase <= 4'h0;
                     cur_tag <= TAG_BRIDGE;
                  end else begin
                     start_step <= start_step + 2'h1;
                     case (start_step)
                        2'h0: cur_tag <= TAG_BRIDGE;
                        2'h1: cur_tag <= TAG_T1_AZ;
                        default: cur_tag <= TAG_T1;
                     endcase
                  end
               end else if (!phase[0] && (rep + 8'h01) < n_count) begin
                  // RL5: stay on the bridge until n samples are taken.
                  rep <= rep + 8'h01;
               end else begin
                  rep <= 8'h00;
                  // RL8: fixed order, wrapping after common mode.
                  if (phase == PHASE_LAST) begin
                     phase <= 4'h0;
                     cur_tag <= TAG_BRIDGE;
                  end else if (phase == 4'h5 && !second_temp_enable) begin
                     // RL6: skip the second temperature slots.
                     phase <= 4'ha;
                     cur_tag <= phase_tag(4'ha);
                  end else begin
                     phase <= phase + 4'h1;
                     cur_tag <= phase_tag(phase + 4'h1);
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Drive multiplexer and input short from the running slot.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         MUX_SEL <= 3'h0;
         AUTO_ZERO <= 1'b0;
      end else begin
         // RL18: multiplexer follows the sequencer.
         MUX_SEL <= cur_tag;
         // RL9: auto-zero slots short the channel input.
         AUTO_ZERO <= (cur_tag == TAG_BRIDGE_AZ) || (cur_tag == TAG_T1_AZ) ||
                      (cur_tag == TAG_T2_AZ);
      end
   end

   // Capture the converter count with its channel at the end of a slot.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         SAMPLE <= '{tag: TAG_BRIDGE, data: 16'h0000};
         SAMPLE_VALID <= 1'b0;
      end else begin
         SAMPLE_VALID <= conv_done;
         if (conv_done) begin
            // RL19: result carries its channel tag.
            SAMPLE <= '{tag: cur_tag, data: CONV_DATA};
         end
      end
   end

endmodule

/* design/bms_pkg.sv */
// Shared constants, types and field layout of the bridge measurement sequencer.
package bms_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 40;                 // System clock period in ns.
   localparam int US_NS = 1000;                // One microsecond in ns.
   localparam int US_CYC = US_NS / CLK_NS;     // Clock cycles per microsecond.

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CYCLE = 8'h00;   // Cycle configuration word.
   localparam logic [7:0] OFS_CONV = 8'h04;    // Converter setup.
   localparam logic [7:0] OFS_XZC = 8'h08;     // Offset pre-compensation.
   localparam logic [7:0] OFS_STATUS = 8'h0c;  // Sequencer state, read only.
   localparam logic [7:0] OFS_RESULT = 8'h10;  // Last sample, read only.

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CYC_N_LO = 7;                // Repeat exponent, bits 9:7.
   localparam int CYC_T2E = 11;                // Second temperature enable.
   localparam int CYC_T1E = 12;                // Main temperature enable.
   localparam int CONV_ORDER = 0;              // 0 first order, 1 second.
   localparam int CONV_RES_LO = 4;             // Resolution, bits 7:4.
   localparam int CONV_RS_LO = 8;              // Range shift, bits 9:8.
   localparam int CONV_REF = 12;               // 0 bridge top, 1 analog supply.
   localparam int XZC_EN = 8;                  // Pre-compensation enable.

   // ----------------------------------------------------------------
   // Reset values and limits
   // ----------------------------------------------------------------
   localparam logic [15:0] CYCLE_RST = 16'h1000;
   localparam logic [15:0] CONV_RST = 16'h00c0;
   localparam logic [8:0] XZC_RST = 9'h100;
   localparam logic [3:0] RES1_MIN = 4'h9;
   localparam logic [3:0] RES1_MAX = 4'he;
   localparam logic [3:0] RES2_MIN = 4'hb;
   localparam logic [3:0] RES2_MAX = 4'hf;
   localparam logic [5:0] XZC_NEG_MAX = 6'h21;  // Minus 31.
   localparam logic [5:0] XZC_NEG_OVR = 6'h20;  // Minus 32, not accepted.
   localparam logic [3:0] PHASE_LAST = 4'hb;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TAG_BRIDGE, TAG_BRIDGE_AZ, TAG_T1_AZ, TAG_T1, TAG_T2_AZ, TAG_T2, TAG_CM
   } bms_tag_t;

   typedef struct packed {
      logic order;        // Converter order.
      logic [3:0] res;    // Resolution in bits.
      logic [1:0] rshift; // Range shift 1/2, 3/4, 7/8, 15/16.
      logic ref_sel;      // Converter reference select.
   } bms_conv_t;

   typedef struct packed {
      bms_tag_t tag;      // Channel the sample belongs to.
      logic [15:0] data;  // Conversion count.
   } bms_sample_t;

endpackage

/* design/bms_tick.sv */
// Microsecond enable divider for conversion timing.
`timescale 1ns/1ps
module bms_tick #(
   parameter int DIV = 25  // Clock cycles per tick.
) (
   input wire logic clk,   // System clock.
   input wire logic rst,   // Synchronous reset.
   output logic tick       // One-cycle pulse each period.
);

   logic [15:0] cnt;       // Cycles left to the next tick.

   // Count down and pulse when the count wraps.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt == 16'h0000) begin
         cnt <= 16'(DIV - 1);
         tick <= 1'b1;
      end else begin
         cnt <= cnt - 16'h0001;
         tick <= 1'b0;
      end
   end

endmodule

/* design/bms_conv_timer.sv */
// Conversion time counter: waits 2 to the power exp microsecond ticks.
`timescale 1ns/1ps
module bms_conv_timer (
   input wire logic clk,         // System clock.
   input wire logic rst,         // Synchronous reset.
   input wire logic tick,        // Microsecond enable.
   input wire logic start,       // Begin a conversion.
   input wire logic [3:0] expo,  // Time exponent.
   output logic done             // One-cycle pulse at the end.
);

   logic [15:0] cnt;             // Ticks still to wait.
   logic busy;                   // A conversion is being timed.

   // Load on start, count ticks, pulse done when the last one passes.
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 16'h0000;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt <= 16'(16'h0001 << expo);
            busy <= 1'b1;
         end else if (busy && tick) begin
            if (cnt == 16'h0001) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            cnt <= cnt - 16'h0001;
         end
      end
   end

endmodule

/* test/bms_conv_model.sv */
// Converter model that answers each conversion start with a count.
`timescale 1ns/1ps
module bms_conv_model (
   input wire logic clk,      // System clock.
   input wire logic rst,      // Synchronous reset, high.
   input wire logic start,    // Conversion start pulse.
   input wire logic [2:0] ch, // Selected channel.
   output logic [15:0] data   // Count, channel in bits 15:13.
);
   logic [2:0] ch_q;  // Channel latched at the start.
   logic [12:0] cnt;  // Free count, so a late sample never sees stale bits.
   // Latch the channel so each result can be traced back to its slot.
   always_ff @(posedge clk) begin
      if (rst) begin
         ch_q <= 3'h0;
      end else if (start) begin
         ch_q <= ch;
      end
   end
   // The low bits change every clock, as a live converter count would.
   always_ff @(posedge clk) begin
      cnt <= rst ? 13'h0 : cnt + 13'h1;
   end
   assign data = {ch_q, cnt};
endmodule

/* test/bms_chk_assertions.sv */
// Port checks of the bridge measurement sequencer.
`timescale 1ns/1ps
module bms_chk (
   input wire logic SYS_CLK,               // Clock.
   input wire logic RST,                   // Reset.
   input wire logic PSEL,                  // APB select.
   input wire logic PENABLE,               // APB access.
   input wire logic PREADY,                // APB ready.
   input wire logic PSLVERR,               // APB error.
   input wire logic [2:0] MUX_SEL,         // Channel.
   input wire logic AUTO_ZERO,             // Input short.
   input wire logic CONV_START,            // Start pulse.
   input wire bms_pkg::bms_conv_t CONV_CFG, // Converter setup.
   input wire logic [4:0] OUT_RES,         // Analog resolution.
   input wire logic [4:0] PWM_RES,         // Pulse-width resolution.
   input wire bms_pkg::bms_sample_t SAMPLE, // Tagged sample.
   input wire logic SAMPLE_VALID           // Sample strobe.
);
   import bms_pkg::*;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // A setup cycle is answered in the next cycle, once.
   ready_next_a: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
      else $error("ready not one cycle after setup");
   err_ready_a: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
      else $error("error outside an access");
   az_slot_a: assert property (
      CONV_START |-> AUTO_ZERO == (MUX_SEL inside {3'h1, 3'h2, 3'h4}))
      else $error("short level wrong for channel");
   tag_mux_a: assert property (SAMPLE_VALID |-> SAMPLE.tag == MUX_SEL)
      else $error("sample tag differs from channel");
   out_cap_a: assert property (
      OUT_RES == ((CONV_CFG.res > 4'hb) ? 5'h0b : {1'b0, CONV_CFG.res}))
      else $error("analog resolution wrong");
   pwm_cap_a: assert property (
      PWM_RES == ((CONV_CFG.res > 4'hc) ? 5'h0c : {1'b0, CONV_CFG.res}))
      else $error("pulse resolution wrong");
   res_span_a: assert property (!$past(RST) |-> (CONV_CFG.order ?
      CONV_CFG.res inside {[4'hb:4'hf]} : CONV_CFG.res inside {[4'h9:4'he]}))
      else $error("resolution out of range");
   mux_hold_a: assert property (CONV_START |=> $stable(MUX_SEL) [*8])
      else $error("channel moved during conversion");
   start_gap_a: assert property (CONV_START |=> !CONV_START && !SAMPLE_VALID [*8])
      else $error("conversion cut short");
   cover property (SAMPLE_VALID && SAMPLE.tag == TAG_T2);
   cover property (SAMPLE_VALID && SAMPLE.tag == TAG_CM);
   cover property (PSLVERR);
endmodule
bind bms_sequencer bms_chk chk_u (.SYS_CLK, .RST, .PSEL, .PENABLE, .PREADY, .PSLVERR,
   .MUX_SEL, .AUTO_ZERO, .CONV_START, .CONV_CFG, .OUT_RES, .PWM_RES, .SAMPLE, .SAMPLE_VALID);

/* test/tb_top.sv */
// Self-checking bench for the bridge measurement sequencer.
`timescale 1ns/1ps
module tb_top;
   import bms_pkg::*;
   logic SYS_CLK = 1'b0; // Clock.
   logic RST = 1'b1; // Reset.
   logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0; // APB request.
   logic [7:0] PADDR = 8'h00; // APB address.
   logic [31:0] PWDATA = 32'h0, PRDATA, rd; // APB data and last read.
   logic PREADY, PSLVERR, err; // APB answer and last error.
   logic [15:0] CONV_DATA; // Converter count.
   logic [2:0] MUX_SEL; // Channel.
   logic AUTO_ZERO, CONV_START, XZC_ENABLE, SAMPLE_VALID; // Levels and strobes.
   logic [4:0] OUT_RES, PWM_RES; // Output resolutions.
   logic [5:0] XZC_CODE; // Step code.
   bms_conv_t CONV_CFG; // Converter setup.
   bms_sample_t SAMPLE, smp; // Sample and last sample.
   int fails = 0, cmp_count = 0, seed = 15; // Counters and seed.
   bms_tag_t exp_q[$]; // Expected tags of one cycle.
   bms_sequencer #(.US_CYCLES(1)) dut_u (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
      .PWDATA, .PRDATA, .PREADY, .PSLVERR, .CONV_DATA, .MUX_SEL, .AUTO_ZERO, .CONV_START,
      .CONV_CFG, .OUT_RES, .PWM_RES, .XZC_CODE, .XZC_ENABLE, .SAMPLE, .SAMPLE_VALID);
   bms_conv_model cm_u (.clk(SYS_CLK), .rst(RST), .start(CONV_START), .ch(MUX_SEL),
      .data(CONV_DATA));
   // Free-running 25 MHz clock.
   initial begin
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One APB transfer; entered and left just after a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge SYS_CLK);
         if (PREADY === 1'b1) break;
      end
      if (k == 20) begin
         fails++;
         end_sim();
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge SYS_CLK);
   endtask
   // Wait for the next sample and check the converter data it carries.
   task automatic get_smp;
      int k;
      for (k = 0; k < 20000; k++) begin
         @(posedge SYS_CLK);
         if (SAMPLE_VALID === 1'b1) break;
      end
      if (k == 20000) begin
         fails++;
         end_sim();
      end
      smp = SAMPLE;
      chk("sample channel", {29'h0, smp.tag}, {29'h0, smp.data[15:13]});
   endtask
   task automatic wait_slot;
      get_smp();
      get_smp();
      repeat (4) @(posedge SYS_CLK);
   endtask
   // Tags of one cycle: n bridge samples before every special slot.
   function automatic void build(input int n, input logic t2);
      bms_tag_t sp[6] = '{TAG_T1_AZ, TAG_T1, TAG_BRIDGE_AZ, TAG_T2_AZ, TAG_T2, TAG_CM};
      exp_q.delete();
      foreach (sp[i]) begin
         if (t2 || (sp[i] != TAG_T2_AZ && sp[i] != TAG_T2)) begin
            repeat (n) exp_q.push_back(TAG_BRIDGE);
            exp_q.push_back(sp[i]);
         end
      end
   endfunction
   function automatic logic [3:0] clamp(input logic o, input logic [3:0] r);
      if (o) return (r < RES2_MIN) ? RES2_MIN : r;
      return (r < RES1_MIN) ? RES1_MIN : ((r > RES1_MAX) ? RES1_MAX : r);
   endfunction
   initial begin
      logic [7:0] tbl[5] = '{8'h08, 8'h0f, 8'h19, 8'h1f, 8'h1b};
      logic [3:0] c;
      logic [1:0] rs;
      logic rf;
      logic [5:0] code;
      int k;
      repeat (8) @(posedge SYS_CLK);
      RST <= 1'b0;
      repeat (2) @(posedge SYS_CLK);
      chk("conv_cfg", 32'h60, {24'h0, CONV_CFG});
      chk("res caps", 32'h0b0c, {19'h0, OUT_RES, 3'h0, PWM_RES});
      chk("xzc", 32'h40, {25'h0, XZC_ENABLE, XZC_CODE});
      for (k = 0; k < 3; k++) begin
         apb(1'b0, 8'(k * 4), 32'h0);
         chk("reset word", (k == 0) ? 32'h1000 : (k == 1) ? 32'hc0 : 32'h100, rd);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h1, {rd[30:0], err});
      $display("test registers done");
      exp_q = '{TAG_BRIDGE_AZ, TAG_BRIDGE, TAG_T1_AZ, TAG_T1};
      foreach (exp_q[i]) begin
         get_smp();
         chk("start tag", {29'h0, exp_q[i]}, {29'h0, smp.tag});
      end
      $display("test start routine done");
      // supply reference only while code is 0; last entry leaves bridge top.
      foreach (tbl[i]) begin
         rs = 2'($random(seed));
         rf = 1'($random(seed)) && i < 4;
         apb(1'b1, OFS_CONV, {19'h0, rf, 2'h0, rs, tbl[i][3:0], 3'h0, tbl[i][4]});
         wait_slot();
         c = clamp(tbl[i][4], tbl[i][3:0]);
         chk("conv_cfg", {24'h0, tbl[i][4], c, rs, rf}, {24'h0, CONV_CFG});
         chk("out_res", (c > 4'hb) ? 32'hb : {28'h0, c}, {27'h0, OUT_RES});
         chk("pwm_res", (c > 4'hc) ? 32'hc : {28'h0, c}, {27'h0, PWM_RES});
      end
      $display("test converter done");
      for (k = 0; k < 8; k++) begin
         code = (k == 0) ? 6'h1f : (k == 1) ? 6'h21 : (k == 2) ? 6'h20 : 6'($random(seed) % 21);
         apb(1'b1, OFS_XZC, {23'h0, k[0], 2'h0, code});
         wait_slot();
         if (code == XZC_NEG_OVR) code = XZC_NEG_MAX;
         chk("xzc out", {25'h0, k[0], code}, {25'h0, XZC_ENABLE, XZC_CODE});
         apb(1'b0, OFS_XZC, 32'h0);
         chk("xzc word", {23'h0, k[0], 2'h0, code}, rd);
      end
      $display("test offset code done");
      for (k = 0; k < 3; k++) begin
         c = (k == 0) ? 4'h1 : (k == 1) ? 4'h0 : 4'($random(seed) & 3);
         rf = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : 1'($random(seed));
         apb(1'b1, OFS_CYCLE, {19'h0, 1'b1, rf, 1'b0, c[2:0], 7'h0});
         build(1 << c, rf);
         code = 0;
         do begin
            get_smp();
            code++;
         end while (smp.tag !== TAG_CM && code < 60);
         foreach (exp_q[i]) begin
            get_smp();
            chk("cycle tag", {29'h0, exp_q[i]}, {29'h0, smp.tag});
         end
      end
      $display("test cycle order done");
      end_sim();
   end
endmodule
